//--- bench/picd_host_model.sv
// Purpose: host processor model for the command decoder bus
// Assumes: every pin moves one step after a clock edge
// Notes:   released data shows the inverse of the last byte written
`timescale 1ns/1ps
module picd_host_model (
	// clock
	input  wire logic       mclk_in,
	// host bus
	output logic            wr_n_out,
	output logic            rd_n_out,
	output logic            sel_out,
	output logic [7:0]      dat_out,
	input  wire logic [7:0] rdat_in,
	input  wire logic       oe_in,
	// requests
	output logic            ack_n_out,
	output logic [7:0]      req_out
);
	initial begin
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		sel_out = 1'b0;
		dat_out = 8'h00;
		ack_n_out = 1'b1;
		req_out = 8'h00;
	end
	// ****************************************
	// bus cycles
	// ****************************************
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : step
	task automatic wr(input logic s, input logic [7:0] v);
		step(1);
		sel_out = s;
		dat_out = v;
		step(6);
		wr_n_out = 1'b0;
		step(6);
		wr_n_out = 1'b1;
		step(6);
		dat_out = ~v;
		step(4);
	endtask : wr
	task automatic rd(input logic s, output logic [7:0] v, output bit ok);
		int i;
		step(1);
		sel_out = s;
		step(2);
		rd_n_out = 1'b0;
		req_out = 8'h00;
		for (i = 0; i < 20 && oe_in !== 1'b1; i++)
			step(1);
		ok = (oe_in === 1'b1);
		step(2);
		v = rdat_in;
		rd_n_out = 1'b1;
		step(8);
	endtask : rd
	task automatic raise(input logic [7:0] v);
		step(1);
		req_out = v;
		step(6);
	endtask : raise
	// request held to ack leading edge
	task automatic ack;
		step(1);
		ack_n_out = 1'b0;
		req_out = 8'h00;
		step(6);
		ack_n_out = 1'b1;
		step(6);
	endtask : ack
endmodule : picd_host_model

//--- bench/tb_top.sv
// Purpose: self-checking bench for the command decoder
// Assumes: the host model makes every bus cycle
// Notes:   integer model tracks mask, requests, service and bottom level
`timescale 1ns/1ps
module tb_top;
	import picd_pkg::*;
	logic        mclk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        ms_pin = 1'b1;
	logic        wr_n, rd_n, sel, ack_n, oe, init_done, single, spacing, cerr, spmask;
	logic [7:0]  dat, rdat, req, svc_o, cmap, v;
	logic [15:0] vbase;
	logic [2:0]  sid, bot;
	bit          ok;
	int          err_total = 0, n_tests = 0;
	int          mask = 0, reqs = 0, svc = 0, bottom = 7;
	always #20 mclk_in = ~mclk_in;
	picd_host_model u_picd_host_model (.mclk_in(mclk_in), .wr_n_out(wr_n), .rd_n_out(rd_n),
		.sel_out(sel), .dat_out(dat), .rdat_in(rdat), .oe_in(oe), .ack_n_out(ack_n), .req_out(req));
	picd_decoder u_picd_decoder (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .write_n_in(wr_n),
		.read_n_in(rd_n), .register_select_line_in(sel), .data_in(dat), .data_out(rdat),
		.data_oe_out(oe), .interrupt_acknowledge_strobe_n_in(ack_n), .request_input_in(req),
		.master_slave_select_pin_in(ms_pin), .vector_base_out(vbase), .spacing_four_out(spacing),
		.single_mode_out(single), .cascade_map_out(cmap), .slave_identity_out(sid),
		.cascade_error_out(cerr), .init_done_out(init_done), .in_service_out(svc_o),
		.bottom_level_out(bot), .special_mask_mode_out(spmask));
	// ****************************************
	// model and checks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	// highest priority set level, 8 when none
	function automatic int top(input int vec, input int b);
		for (int i = 0; i < 8; i++)
			if (vec[(b + 1 + i) % 8])
				return (b + 1 + i) % 8;
		return 8;
	endfunction : top
	task automatic rdc(input logic s, input logic [7:0] exp);
		u_picd_host_model.rd(s, v, ok);
		chk(ok, 1'b1);
		chk(v, exp);
		chk(oe, 1'b0);
	endtask : rdc
	task automatic do_ack(input int bits);
		int l;
		u_picd_host_model.raise(bits[7:0]);
		reqs |= bits;
		u_picd_host_model.ack();
		l = top(reqs & ~mask, bottom);
		if (l < 8) begin
			svc |= 1 << l;
			reqs &= ~(1 << l);
		end
	endtask : do_ack
	initial begin
		repeat (100000) @(posedge mclk_in);
		err_total++;
		stop_test();
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		int a, c, l, t, m;
		logic [7:0] fb, vh, c3;
		a = $urandom(32'hb46b);
		repeat (2) @(posedge mclk_in);
		#1;
		reset_n_in = 1'b1;
		repeat (4) @(posedge mclk_in);
		#1;
		chk({oe, svc_o, bot, init_done, single}, {1'b0, 8'h00, 3'h7, 1'b0, 1'b1});
		u_picd_host_model.wr(1'b1, 8'h55);
		chk(init_done, 1'b0);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			a = $urandom();
			vh = 8'($urandom());
			c3 = 8'($urandom());
			fb = {a[7:5], 2'b10, k[1], k[0], 1'b0};
			ms_pin = k[1];
			u_picd_host_model.wr(1'b0, fb);
			chk(init_done, 1'b0);
			u_picd_host_model.wr(1'b1, vh);
			if (!k[0])
				u_picd_host_model.wr(1'b1, c3);
			chk(vbase, {vh, fb[7:5], 5'h00});
			chk(spacing, k[1]);
			chk(single, k[0]);
			chk(init_done, 1'b1);
			if (!k[0] && k[1])
				chk(cmap, c3);
			if (!k[0] && !k[1])
				chk({cerr, sid}, {|c3[7:3], c3[2:0]});
		end
		$display("test init done");
		m = $urandom();
		u_picd_host_model.wr(1'b1, m[7:0]);
		rdc(1'b1, m[7:0]);
		mask = 1 << m[2:0];
		u_picd_host_model.wr(1'b1, mask[7:0]);
		do_ack(mask);
		$display("test mask done");
		for (c = 0; c < 8; c++) begin
			a = $urandom();
			do_ack(1 << ((bottom + 5 + a[1:0]) % 8));
			do_ack(1 << ((bottom + 1 + a[3:2]) % 8));
			chk(svc_o, svc[7:0]);
			l = (c == 3 || c > 5) ? a[6:4] : 0;
			u_picd_host_model.wr(1'b0, 8'(c * 32 + l));
			t = top(svc, bottom);
			if (c == 1 || c == 5)
				l = t;
			if (c == 1 || c == 3 || c == 5 || c == 7)
				svc &= ~(1 << l);
			if (c >= 5)
				bottom = l;
			chk(svc_o, svc[7:0]);
			chk(bot, bottom[2:0]);
		end
		$display("test service done");
		u_picd_host_model.wr(1'b0, 8'h0a);
		rdc(1'b0, reqs[7:0]);
		rdc(1'b0, reqs[7:0]);
		u_picd_host_model.wr(1'b0, 8'h0b);
		rdc(1'b0, svc[7:0]);
		a = $urandom();
		u_picd_host_model.wr(1'b0, {a[0], 7'h68});
		chk(spmask, 1'b1);
		u_picd_host_model.wr(1'b0, {a[1], 7'h48});
		chk(spmask, 1'b0);
		$display("test status done");
		mask = 0;
		u_picd_host_model.wr(1'b1, 8'h00);
		u_picd_host_model.raise(8'(1 << a[4:2]));
		reqs |= 1 << a[4:2];
		for (c = 0; c < 3; c++) begin
			u_picd_host_model.wr(1'b0, 8'h0c);
			t = top(reqs, bottom);
			u_picd_host_model.rd(1'b0, v, ok);
			chk(ok, 1'b1);
			chk(v[7], t < 8);
			if (t < 8) begin
				chk(v[2:0], t[2:0]);
				svc |= 1 << t;
				reqs &= ~(1 << t);
			end
			chk(svc_o, svc[7:0]);
		end
		$display("test poll done");
		stop_test();
	end
endmodule : tb_top

//--- design/picd_decoder.sv
// Purpose: command word decoder of an eight input priority interrupt controller
// Assumes: strobes and requests arrive asynchronously; host holds data steady across a write
// Notes:   writes act on the trailing edge of the write strobe; reads drive while the strobe is low
// Operation
// - select-low bit4 write is first init byte
// - bit2 picks four or eight byte spacing
// - bit1 clear means cascaded, third byte follows
// - second init byte gives vector bits 15..8
// - master third byte maps slave inputs
// - slave third byte carries three-bit identity
// - master when select pin high
// - select-high write loads mask, read returns it
// - non-specific and specific end of service
// - automatic rotate at end of service
// - specific end plus bottom priority set
// - set bottom priority without clearing service
// - read-mode word sets or resets special mask
// - poll word turns next select-low read into acknowledge
// - poll byte: pending flag plus level code
// - status select kept until changed
`timescale 1ns/1ps
module picd_decoder (
	// clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  reset_n_in,
	// host bus
	input  wire logic                  write_n_in,
	input  wire logic                  read_n_in,
	input  wire logic                  register_select_line_in,
	input  wire logic [7:0]            data_in,
	output logic      [7:0]            data_out,
	output logic                       data_oe_out,
	// acknowledge and requests
	input  wire logic                  interrupt_acknowledge_strobe_n_in,
	input  wire logic [7:0]            request_input_in,
	input  wire logic                  master_slave_select_pin_in,
	// decoded configuration
	output logic      [15:0]           vector_base_out,
	output logic                       spacing_four_out,
	output logic                       single_mode_out,
	output logic      [7:0]            cascade_map_out,
	output logic      [2:0]            slave_identity_out,
	output logic                       cascade_error_out,
	output logic                       init_done_out,
	output logic      [7:0]            in_service_out,
	output logic      [2:0]            bottom_level_out,
	output logic                       special_mask_mode_out
);
	import picd_pkg::*;

	// ************
	// synchronisers
	// ************
	logic [PICD_SYNC_STAGES-1:0] sync_wr;
	logic [PICD_SYNC_STAGES-1:0] sync_rd;
	logic [PICD_SYNC_STAGES-1:0] sync_ack;
	logic [PICD_SYNC_STAGES-1:0] sync_sel;
	logic [PICD_SYNC_STAGES-1:0] sync_ms;
	logic [7:0]                  sync_req [PICD_SYNC_STAGES];
	logic [7:0]                  sync_data [PICD_SYNC_STAGES];

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_wr  <= '1;
			sync_rd  <= '1;
			sync_ack <= '1;
			sync_sel <= '0;
			sync_ms  <= '1;
			for (int i = 0; i < PICD_SYNC_STAGES; i++) begin
				sync_req[i]  <= PICD_BYTE_ZERO;
				sync_data[i] <= PICD_BYTE_ZERO;
			end
		end else begin
			sync_wr  <= {sync_wr[PICD_SYNC_STAGES-2:0], write_n_in};
			sync_rd  <= {sync_rd[PICD_SYNC_STAGES-2:0], read_n_in};
			sync_ack <= {sync_ack[PICD_SYNC_STAGES-2:0], interrupt_acknowledge_strobe_n_in};
			sync_sel <= {sync_sel[PICD_SYNC_STAGES-2:0], register_select_line_in};
			sync_ms  <= {sync_ms[PICD_SYNC_STAGES-2:0], master_slave_select_pin_in};
			sync_req[0]  <= request_input_in;
			sync_data[0] <= data_in;
			for (int i = 1; i < PICD_SYNC_STAGES; i++) begin
				sync_req[i]  <= sync_req[i-1];
				sync_data[i] <= sync_data[i-1];
			end
		end
	end

	// ************
	// helpers
	// ************
	function automatic logic [7:0] picd_onehot(input logic [2:0] lvl);
		picd_onehot = 8'h01 << lvl;
	endfunction : picd_onehot

	// highest priority set bit, lowest priority level is bottom
	function automatic logic [3:0] picd_highest(input logic [7:0] bits, input logic [2:0] bottom);
		logic [2:0] lvl;
		picd_highest = 4'h0;
		for (int k = PICD_NUM_LEVELS - 1; k >= 0; k--) begin
			lvl = 3'(bottom + 3'(k + 1));
			if (bits[lvl]) begin
				picd_highest = {1'b1, lvl};
			end
		end
	endfunction : picd_highest

	// ************
	// filtered bus view
	// ************
	picd_state_t state;
	picd_state_t next_state;
	picd_bus_t   bus_now;
	logic        is_master;
	logic [7:0]  wdata;
	logic [7:0]  req_now;

	// changes count when stages two and three agree
	always_comb begin
		bus_now.wr_n  = (sync_wr[1] == sync_wr[2]) ? sync_wr[2] : state.prev_bus.wr_n;
		bus_now.rd_n  = (sync_rd[1] == sync_rd[2]) ? sync_rd[2] : state.prev_bus.rd_n;
		bus_now.ack_n = (sync_ack[1] == sync_ack[2]) ? sync_ack[2] : state.prev_bus.ack_n;
		bus_now.sel   = (sync_sel[1] == sync_sel[2]) ? sync_sel[2] : state.prev_bus.sel;
		wdata         = sync_data[2];
		req_now       = sync_req[2];
	end

	assign is_master = sync_ms[2];

	// ************
	// main state
	// ************
	logic        wr_done;
	logic        rd_start;
	logic        ack_start;
	logic [3:0]  hi_req;
	logic [3:0]  hi_svc;
	logic [7:0]  pending;

	assign wr_done   = !state.prev_bus.wr_n && bus_now.wr_n;
	assign rd_start  = state.prev_bus.rd_n && !bus_now.rd_n;
	assign ack_start = state.prev_bus.ack_n && !bus_now.ack_n;
	assign pending   = state.request_register & ~state.mask_register;
	assign hi_req    = picd_highest(pending, state.bottom_level);
	assign hi_svc    = picd_highest(state.in_service_register, state.bottom_level);

	always_comb begin
		next_state          = state;
		next_state.prev_bus = bus_now;
		// requests latched, held by source until acknowledge
		next_state.request_register = state.request_register | req_now;
		if (wr_done && !state.prev_bus.sel && wdata[PICD_INIT_FLAG_BIT]) begin
			next_state.init_state        = PICD_ST_WAIT_VECTOR;
			next_state.vector_low        = {wdata[7:5], 5'h00};
			next_state.spacing_four      = wdata[PICD_SPACING_BIT];
			next_state.single_mode       = wdata[PICD_SINGLE_BIT];
			next_state.mask_register     = PICD_MASK_RESET;
			next_state.in_service_register = PICD_BYTE_ZERO;
			next_state.bottom_level      = PICD_BOTTOM_RESET;
			next_state.special_mask_mode = 1'b0;
			next_state.status_select_bit = 1'b0;
			next_state.poll_armed        = 1'b0;
		end else if (wr_done && state.prev_bus.sel) begin
			unique case (state.init_state)
				PICD_ST_WAIT_FIRST: begin
					next_state.init_state = PICD_ST_WAIT_FIRST;
				end
				PICD_ST_WAIT_VECTOR: begin
					next_state.vector_high = wdata;
					next_state.init_state  = state.single_mode ? PICD_ST_READY : PICD_ST_WAIT_CASCADE;
				end
				PICD_ST_WAIT_CASCADE: begin
					if (is_master) begin
						next_state.cascade_map = wdata;
					end else begin
						// slave identity, upper bits must be zero
						next_state.slave_identity = wdata[2:0];
						next_state.cascade_err    = |wdata[7:3];
					end
					next_state.init_state = PICD_ST_READY;
				end
				PICD_ST_READY: begin
					next_state.mask_register = wdata;
				end
			endcase
		end else if (wr_done && state.init_state == PICD_ST_READY) begin
			if (wdata[4:3] == PICD_CLASS_SERVICE) begin
				unique case (wdata[7:5])
					PICD_SVC_END: begin
						if (hi_svc[3])
							next_state.in_service_register = state.in_service_register & ~picd_onehot(hi_svc[2:0]);
					end
					PICD_SVC_SPEC_END: begin
						next_state.in_service_register = state.in_service_register & ~picd_onehot(wdata[2:0]);
					end
					PICD_SVC_ROT_END: begin
						if (hi_svc[3]) begin
							next_state.in_service_register = state.in_service_register & ~picd_onehot(hi_svc[2:0]);
							next_state.bottom_level = hi_svc[2:0];
						end
					end
					PICD_SVC_ROT_SET: begin
						next_state.bottom_level = wdata[2:0];
					end
					PICD_SVC_ROT_SPEC: begin
						next_state.in_service_register = state.in_service_register & ~picd_onehot(wdata[2:0]);
						next_state.bottom_level = wdata[2:0];
					end
					default: begin
						next_state.bottom_level = state.bottom_level;
					end
				endcase
			end else if (wdata[4:3] == PICD_CLASS_READ) begin
				if (wdata[PICD_SPMASK_EN_BIT])
					next_state.special_mask_mode = wdata[PICD_SPMASK_VAL_BIT];
				if (wdata[PICD_STAT_EN_BIT])
					next_state.status_select_bit = wdata[PICD_STAT_SEL_BIT];
				next_state.poll_armed = wdata[PICD_POLL_BIT];
			end
		end
		// read path
		if (rd_start) begin
			next_state.read_oe = 1'b1;
			if (state.prev_bus.sel) begin
				next_state.read_data = state.mask_register;
			end else if (state.poll_armed) begin
				next_state.read_data = {hi_req[3], 4'h0, hi_req[2:0]};
				next_state.poll_armed = 1'b0;
				if (hi_req[3]) begin
					next_state.in_service_register = next_state.in_service_register | picd_onehot(hi_req[2:0]);
					next_state.request_register = req_now | (state.request_register & ~picd_onehot(hi_req[2:0]));
				end
			end else begin
				next_state.read_data = state.status_select_bit ? state.in_service_register : state.request_register;
			end
		end else if (bus_now.rd_n) begin
			next_state.read_oe = 1'b0;
		end
		// acknowledge marks highest request in service
		if (ack_start && hi_req[3] && state.init_state == PICD_ST_READY) begin
			next_state.in_service_register = next_state.in_service_register | picd_onehot(hi_req[2:0]);
			next_state.request_register = req_now | (state.request_register & ~picd_onehot(hi_req[2:0]));
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state                     <= '0;
			state.init_state          <= PICD_ST_WAIT_FIRST;
			state.single_mode         <= 1'b1;
			state.bottom_level        <= PICD_BOTTOM_RESET;
			state.mask_register       <= PICD_MASK_RESET;
			state.prev_bus            <= '{wr_n: 1'b1, rd_n: 1'b1, ack_n: 1'b1, sel: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// ************
	// outputs
	// ************
	assign data_out              = state.read_data;
	assign data_oe_out           = state.read_oe;
	assign vector_base_out       = {state.vector_high, state.vector_low};
	assign spacing_four_out      = state.spacing_four;
	assign single_mode_out       = state.single_mode;
	assign cascade_map_out       = state.cascade_map;
	assign slave_identity_out    = state.slave_identity;
	assign cascade_error_out     = state.cascade_err;
	assign init_done_out         = state.init_state == PICD_ST_READY;
	assign in_service_out        = state.in_service_register;
	assign bottom_level_out      = state.bottom_level;
	assign special_mask_mode_out = state.special_mask_mode;

	// ************
	// assertions
	// ************
	AST_FIRST_BYTE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_done && !state.prev_bus.sel && wdata[4]) |=> (state.init_state == PICD_ST_WAIT_VECTOR))
		else $error("first init byte not taken");
	AST_SPACING: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(wr_done && !state.prev_bus.sel && wdata[4]) |=> (spacing_four_out == $past(wdata[2])))
		else $error("spacing bit wrong");
	AST_SINGLE_SKIP: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(state.init_state == PICD_ST_WAIT_VECTOR && wr_done && state.prev_bus.sel && state.single_mode)
		|=> init_done_out)
		else $error("single mode did not skip third byte");
	AST_VECTOR_HIGH: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(state.init_state == PICD_ST_WAIT_VECTOR && wr_done && state.prev_bus.sel)
		|=> (vector_base_out[15:8] == $past(wdata)))
		else $error("vector high not loaded");
	AST_SLAVE_ERR: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(state.init_state == PICD_ST_WAIT_CASCADE && wr_done && state.prev_bus.sel && !is_master)
		|=> (cascade_error_out == |$past(wdata[7:3])))
		else $error("slave identity check wrong");
	AST_MASK_LOAD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(init_done_out && wr_done && state.prev_bus.sel && !(!state.prev_bus.sel))
		|=> (state.mask_register == $past(wdata)))
		else $error("mask not loaded");
	AST_ROT_SET: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(init_done_out && wr_done && !state.prev_bus.sel && wdata[7:3] == 5'h18)
		|=> (bottom_level_out == $past(wdata[2:0])) && $stable(in_service_out))
		else $error("rotate set misbehaved");
	AST_SPECIAL_MASK: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(init_done_out && wr_done && !state.prev_bus.sel && wdata[6:3] == 4'hD)
		|=> special_mask_mode_out)
		else $error("special mask not set");
	AST_POLL_ONCE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(rd_start && !state.prev_bus.sel && state.poll_armed) |=> !state.poll_armed)
		else $error("poll not single use");
	COV_CASCADE: cover property (@(posedge mclk_in) state.init_state == PICD_ST_WAIT_CASCADE ##1 init_done_out);
	COV_POLL: cover property (@(posedge mclk_in) rd_start && state.poll_armed && hi_req[3]);
	COV_ACK: cover property (@(posedge mclk_in) ack_start && hi_req[3]);
endmodule : picd_decoder

//--- design/picd_pkg.sv
// Purpose: shared constants and types for the priority interrupt command decoder
// Assumes: 8-bit host bus qualified by one register select line
// Notes:   field positions and command codes of the command words
package picd_pkg;
	localparam int          PICD_NUM_LEVELS   = 8;
	localparam int          PICD_SYNC_STAGES  = 3;
	// first init byte fields
	localparam int          PICD_INIT_FLAG_BIT = 4;
	localparam int          PICD_SPACING_BIT   = 2;
	localparam int          PICD_SINGLE_BIT    = 1;
	// command class from bits 4..3 on select-low writes
	localparam logic [1:0]  PICD_CLASS_SERVICE = 2'h0;
	localparam logic [1:0]  PICD_CLASS_READ    = 2'h1;
	// service / priority word codes in bits 7..5
	localparam logic [2:0]  PICD_SVC_END       = 3'h1;
	localparam logic [2:0]  PICD_SVC_SPEC_END  = 3'h3;
	localparam logic [2:0]  PICD_SVC_ROT_END   = 3'h5;
	localparam logic [2:0]  PICD_SVC_ROT_SET   = 3'h6;
	localparam logic [2:0]  PICD_SVC_ROT_SPEC  = 3'h7;
	// read-mode word fields
	localparam int          PICD_SPMASK_EN_BIT  = 6;
	localparam int          PICD_SPMASK_VAL_BIT = 5;
	localparam int          PICD_POLL_BIT      = 2;
	localparam int          PICD_STAT_EN_BIT   = 1;
	localparam int          PICD_STAT_SEL_BIT  = 0;
	localparam int          PICD_PENDING_BIT   = 7;
	localparam logic [7:0]  PICD_MASK_RESET    = 8'h00;
	localparam logic [7:0]  PICD_BYTE_ZERO     = 8'h00;
	localparam logic [2:0]  PICD_BOTTOM_RESET  = 3'h7;

	typedef enum logic [1:0] {
		PICD_ST_WAIT_FIRST,
		PICD_ST_WAIT_VECTOR,
		PICD_ST_WAIT_CASCADE,
		PICD_ST_READY
	} picd_init_state_t;

	// host bus pins after synchronisation
	typedef struct packed {
		logic       wr_n;
		logic       rd_n;
		logic       ack_n;
		logic       sel;
	} picd_bus_t;

	typedef struct packed {
		picd_init_state_t init_state;
		logic [7:0]       vector_low;
		logic [7:0]       vector_high;
		logic             spacing_four;
		logic             single_mode;
		logic [7:0]       cascade_map;
		logic [2:0]       slave_identity;
		logic             cascade_err;
		logic [7:0]       mask_register;
		logic [7:0]       request_register;
		logic [7:0]       in_service_register;
		logic [2:0]       bottom_level;
		logic             special_mask_mode;
		logic             status_select_bit;
		logic             poll_armed;
		logic [7:0]       read_data;
		logic             read_oe;
		picd_bus_t        prev_bus;
	} picd_state_t;
endpackage : picd_pkg
